// ### design/lock_gate_map.vh
// What this block does
// - reset clears the whole lock register
// - bit 7 locks wake-up controller from host
// - blocked cycle answered per response-mode field
// - blocked host access sets the violation flag
// - wake-up lock spares the ACPI registers
// - locked module is forced active
// - bit 6 locks the real-time clock
// - bit 5 locks the extension-bus module
// - bit 3 locks chip select 3 devices
// - zero bit leaves target open, default
// - bits 2..0 lock chip selects 2..0
`ifndef LOCK_GATE_MAP_VH
`define LOCK_GATE_MAP_VH

// register indices; byte address is four times the index
`define IDX_SERIAL_BUS_CTRL_STATUS 6'h00
`define IDX_SERIAL_BUS_CONFIG 6'h01
`define IDX_HOST_BUS_LOCK_CONFIG_TWO 6'h06
`define IDX_MODULE_ACTIVE 6'h07
`define IDX_VIOLATION_SOURCE 6'h08

// field positions
`define BIT_ACCESS_VIOLATION_FLAG 2
`define BIT_RESP_MODE_LO 4
`define BIT_RESP_MODE_HI 5
`define BIT_WAKEUP_CTRL_LOCK 7
`define BIT_RTC_LOCK 6
`define BIT_EXTENSION_MODULE_LOCK 5
`define BIT_RESERVED_LOCK 4
`define BIT_EXT_CHIP_SELECT3_LOCK 3
`define BIT_EXT_CHIP_SELECT2_LOCK 2
`define BIT_EXT_CHIP_SELECT1_LOCK 1
`define BIT_EXT_CHIP_SELECT0_LOCK 0

// writable lock bits; bit 4 is reserved and reads zero
`define LOCK_WRITE_MASK 8'hEF

// reset values
`define RST_LOCK_CONFIG_TWO 8'h00
`define RST_RESP_MODE 2'h0
`define RST_FLAG 1'b0

`endif

// ### design/lock_gate_cell.v
`timescale 1ns/1ns
// gating for one controlled target
module lock_gate_cell (
  input wire lock,
  input wire act_cfg,
  input wire glob_en,
  input wire lpc_hit,
  output wire lpc_pass,
  output wire lpc_violate,
  output wire active
);
  assign lpc_pass = lpc_hit & ~lock;
  assign lpc_violate = lpc_hit & lock;
  // lock overrides both activation bits
  assign active = lock | (act_cfg & glob_en);
endmodule

// ### design/access_lock_gate.v
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "lock_gate_map.vh"
module access_lock_gate #(
  parameter ADDR_W = 8
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [7:0] act_cfg,
  input wire global_module_enable,
  input wire lpc_req,
  input wire lpc_wr,
  input wire [7:0] lpc_sel,
  input wire [7:0] lpc_wdata,
  input wire lpc_acpi_req,
  input wire smb_req,
  input wire smb_wr,
  input wire [7:0] smb_sel,
  input wire [7:0] smb_wdata,
  output reg lpc_fwd,
  output reg lpc_fwd_wr,
  output reg [7:0] lpc_fwd_sel,
  output reg [7:0] lpc_fwd_wdata,
  output reg lpc_acpi_fwd,
  output reg lpc_violation,
  output reg [1:0] lpc_violation_mode,
  output reg smb_fwd,
  output reg smb_fwd_wr,
  output reg [7:0] smb_fwd_sel,
  output reg [7:0] smb_fwd_wdata,
  output reg [7:0] module_active
);
  localparam ST_IDLE = 2'b01;
  localparam ST_ACK = 2'b10;

  reg [1:0] bus_state_r;
  reg [1:0] bus_state_nxt;
  reg [7:0] lock_r;
  reg [1:0] resp_mode_r;
  reg flag_r;
  reg [7:0] viol_src_r;
  reg [31:0] rdata_nxt;

  wire [7:0] lock_eff;
  wire [7:0] pass_v;
  wire [7:0] viol_v;
  wire [7:0] active_v;
  wire [5:0] word_idx;
  wire req;
  wire wr_fire;
  wire any_viol;
  wire flag_clr;
  wire [7:0] src_clr;

  // reserved bit never locks anything, so the ACPI path is never on it
  assign lock_eff = lock_r & `LOCK_WRITE_MASK;
  assign word_idx = avs_address[7:2];
  assign req = avs_read | avs_write;
  // a write lands only at the edge where waitrequest is seen low
  assign wr_fire = avs_write & (bus_state_r == ST_ACK);

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gate
      lock_gate_cell u_cell (
        .lock(lock_eff[g]),
        .act_cfg(act_cfg[g]),
        .glob_en(global_module_enable),
        .lpc_hit(lpc_req & lpc_sel[g]),
        .lpc_pass(pass_v[g]),
        .lpc_violate(viol_v[g]),
        .active(active_v[g])
      );
    end
  endgenerate

  assign any_viol = |viol_v;
  assign flag_clr = wr_fire & (word_idx == `IDX_SERIAL_BUS_CTRL_STATUS) &
    avs_writedata[`BIT_ACCESS_VIOLATION_FLAG];
  assign src_clr = (wr_fire & (word_idx == `IDX_VIOLATION_SOURCE)) ?
    avs_writedata[7:0] : 8'h00;

  always @* begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      ST_IDLE: begin
        if (req) begin
          bus_state_nxt = ST_ACK;
        end
      end
      ST_ACK: begin
        bus_state_nxt = ST_IDLE;
      end
      default: begin
        bus_state_nxt = ST_IDLE;
      end
    endcase
  end

  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (word_idx)
      `IDX_SERIAL_BUS_CTRL_STATUS: begin
        rdata_nxt[`BIT_ACCESS_VIOLATION_FLAG] = flag_r;
      end
      `IDX_SERIAL_BUS_CONFIG: begin
        rdata_nxt[`BIT_RESP_MODE_HI:`BIT_RESP_MODE_LO] = resp_mode_r;
      end
      `IDX_HOST_BUS_LOCK_CONFIG_TWO: begin
        rdata_nxt[7:0] = lock_eff;
      end
      `IDX_MODULE_ACTIVE: begin
        rdata_nxt[7:0] = module_active;
      end
      `IDX_VIOLATION_SOURCE: begin
        rdata_nxt[7:0] = viol_src_r;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // register bus slave: one wait state on every access
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_state_r <= ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      bus_state_r <= bus_state_nxt;
      avs_waitrequest <= ~(bus_state_r == ST_IDLE && req);
      if (bus_state_r == ST_IDLE && avs_read) begin
        avs_readdata <= rdata_nxt;
      end
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_r <= `RST_LOCK_CONFIG_TWO;
      resp_mode_r <= `RST_RESP_MODE;
      flag_r <= `RST_FLAG;
      viol_src_r <= 8'h00;
    end else begin
      if (wr_fire && word_idx == `IDX_HOST_BUS_LOCK_CONFIG_TWO) begin
        lock_r <= avs_writedata[7:0] & `LOCK_WRITE_MASK;
      end
      if (wr_fire && word_idx == `IDX_SERIAL_BUS_CONFIG) begin
        resp_mode_r <= avs_writedata[`BIT_RESP_MODE_HI:`BIT_RESP_MODE_LO];
      end
      // a violation in the clearing cycle keeps the flag set
      flag_r <= (flag_r & ~flag_clr) | any_viol;
      viol_src_r <= (viol_src_r & ~src_clr) | viol_v;
    end
  end

  // host-bus side: locked targets see nothing, not even the write data
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lpc_fwd <= 1'b0;
      lpc_fwd_wr <= 1'b0;
      lpc_fwd_sel <= 8'h00;
      lpc_fwd_wdata <= 8'h00;
      lpc_acpi_fwd <= 1'b0;
      lpc_violation <= 1'b0;
      lpc_violation_mode <= `RST_RESP_MODE;
    end else begin
      lpc_fwd <= |pass_v;
      lpc_fwd_wr <= lpc_wr & (|pass_v);
      lpc_fwd_sel <= pass_v;
      lpc_fwd_wdata <= (|pass_v) ? lpc_wdata : 8'h00;
      lpc_acpi_fwd <= lpc_acpi_req;
      lpc_violation <= any_viol;
      lpc_violation_mode <= resp_mode_r;
    end
  end

  // serial-bus side: the lock never gates serial-bus traffic, only module_active
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      smb_fwd <= 1'b0;
      smb_fwd_wr <= 1'b0;
      smb_fwd_sel <= 8'h00;
      smb_fwd_wdata <= 8'h00;
      module_active <= 8'h00;
    end else begin
      smb_fwd <= smb_req;
      smb_fwd_wr <= smb_req & smb_wr;
      smb_fwd_sel <= smb_req ? smb_sel : 8'h00;
      smb_fwd_wdata <= smb_req ? smb_wdata : 8'h00;
      module_active <= active_v;
    end
  end
endmodule

// ### verification/host_model.sv
`timescale 1ns/1ns
module host_model (
  input wire sys_clk,
  output reg lpc_req,
  output reg lpc_wr,
  output reg [7:0] lpc_sel,
  output reg [7:0] lpc_wdata,
  output reg lpc_acpi_req,
  output reg smb_req,
  output reg smb_wr,
  output reg [7:0] smb_sel,
  output reg [7:0] smb_wdata
);
  initial begin
    {lpc_req, lpc_acpi_req, smb_req, lpc_wr, smb_wr} = 5'h00;
    {lpc_sel, lpc_wdata, smb_sel, smb_wdata} = 32'h0;
  end
  // k: bit0 host, bit1 acpi, bit2 serial
  task issue(input [2:0] k, input [7:0] s, d);
    @(posedge sys_clk);
    {smb_req, lpc_acpi_req, lpc_req} <= k;
    {lpc_wr, smb_wr} <= 2'h3;
    {lpc_sel, smb_sel, lpc_wdata, smb_wdata} <= {s, s, d, d};
    @(posedge sys_clk);
    {smb_req, lpc_acpi_req, lpc_req} <= 3'h0;
    // stale values must not look valid
    {lpc_sel, smb_sel, lpc_wdata, smb_wdata} <= ~{s, s, d, d};
  endtask
endmodule

// ### verification/lock_asserts.sv
`timescale 1ns/1ns
module lock_asserts (
  input wire sys_clk,
  input wire sys_rst,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire lpc_req,
  input wire [7:0] lpc_sel,
  input wire lpc_acpi_req,
  input wire smb_req,
  input wire lpc_fwd,
  input wire [7:0] lpc_fwd_wdata,
  input wire lpc_acpi_fwd,
  input wire lpc_violation,
  input wire smb_fwd,
  input wire [7:0] module_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_bus_open;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_host_hit;
    lpc_req && lpc_sel != 8'h00;
  endsequence
  a_bus_one_wait: assert property (s_bus_open |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus wait");
  a_host_answer: assert property (s_host_hit |=> lpc_fwd != lpc_violation)
    else $error("host answer");
  a_no_stray_viol: assert property (!lpc_req |=> !lpc_violation)
    else $error("stray violation");
  a_no_stray_fwd: assert property (!lpc_req |=> !lpc_fwd)
    else $error("stray forward");
  a_acpi_open: assert property (lpc_acpi_req |=> lpc_acpi_fwd)
    else $error("acpi blocked");
  a_serial_open: assert property (smb_req |=> smb_fwd)
    else $error("serial blocked");
  a_blocked_quiet: assert property (lpc_violation |-> !lpc_fwd && lpc_fwd_wdata == 8'h00)
    else $error("blocked leak");
  a_locked_active: assert property (lpc_violation |-> (module_active & $past(lpc_sel)) != 0)
    else $error("locked inactive");
endmodule
bind access_lock_gate lock_asserts u_chk (.sys_clk, .sys_rst, .avs_read, .avs_write,
  .avs_waitrequest, .lpc_req, .lpc_sel, .lpc_acpi_req, .smb_req, .lpc_fwd, .lpc_fwd_wdata,
  .lpc_acpi_fwd, .lpc_violation, .smb_fwd, .module_active);

// ### verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  reg sys_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, glb = 0;
  reg [7:0] avs_address = 8'h00, act_cfg = 8'h00;
  reg [31:0] avs_writedata = 32'h0, q;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, lpc_req, lpc_wr, lpc_acpi_req, smb_req, smb_wr;
  wire lpc_fwd, lpc_acpi_fwd, lpc_violation, smb_fwd;
  wire [1:0] mode;
  wire [7:0] lpc_sel, lpc_wdata, smb_sel, smb_wdata, fsel, fwd, module_active;
  wire [7:0] ssel, swd;
  wire fwr, sw;
  integer n_errors = 0, n_compared = 0, b;
  always #20 sys_clk = ~sys_clk;
  host_model host (.sys_clk, .lpc_req, .lpc_wr, .lpc_sel, .lpc_wdata, .lpc_acpi_req,
    .smb_req, .smb_wr, .smb_sel, .smb_wdata);
  access_lock_gate dut (.sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .act_cfg, .global_module_enable(glb),
    .lpc_req, .lpc_wr, .lpc_sel, .lpc_wdata, .lpc_acpi_req, .smb_req, .smb_wr, .smb_sel,
    .smb_wdata, .lpc_fwd, .lpc_fwd_wr(fwr), .lpc_fwd_sel(fsel), .lpc_fwd_wdata(fwd),
    .lpc_acpi_fwd, .lpc_violation, .lpc_violation_mode(mode), .smb_fwd, .smb_fwd_wr(sw),
    .smb_fwd_sel(ssel), .smb_fwd_wdata(swd), .module_active);
  task test_done;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input [63:0] nm, input [31:0] e, s);
    n_compared = n_compared + 1;
    if (e !== s) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0s exp %h got %h", nm, e, s);
    end
  endtask
  task bus(input w, input [7:0] a, d);
    integer i;
    @(posedge sys_clk);
    {avs_read, avs_write} <= {!w, w};
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    i = 0;
    do begin
      @(posedge sys_clk);
      i = i + 1;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    q = avs_readdata;
    {avs_read, avs_write} <= 2'h0;
    chk("wait", 0, avs_waitrequest);
    if (avs_waitrequest !== 1'b0) test_done;
  endtask
  task scen(input [7:0] m);
    bus(1, 8'h18, m);
    host.issue(3'h7, m, 8'hA5);
    @(negedge sys_clk);
    chk("viol", 1, lpc_violation);
    chk("fwd", 0, {lpc_fwd, fsel, fwd});
    chk("mode", 2, mode);
    chk("acpi", 3, {lpc_acpi_fwd, smb_fwd});
    chk("act", m, module_active);
    chk("smb", {1'b1, m, 8'hA5}, {sw, ssel, swd});
    bus(0, 8'h00, 0);
    chk("flag", 1, q[2]);
    bus(0, 8'h20, 0);
    chk("src", m, q);
    bus(1, 8'h20, m);
    bus(1, 8'h00, 8'h04);
    bus(1, 8'h18, 8'h00);
    host.issue(3'h1, m, 8'hA5);
    @(negedge sys_clk);
    chk("open", {2'h2, m}, {lpc_fwd, lpc_violation, fsel});
    chk("fwr", {1'b1, 8'hA5}, {fwr, fwd});
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 0;
    bus(0, 8'h18, 0);
    chk("lock", 0, q);
    bus(0, 8'h3C, 0);
    chk("unmap", 0, q);
    bus(1, 8'h04, 8'h20);
    bus(1, 8'h18, 8'hFF);
    bus(0, 8'h18, 0);
    chk("rsvd", 8'hEF, q);
    for (b = 0; b < 8; b = b + 1) if (b != 4) scen(8'h01 << b);
    @(posedge sys_clk);
    act_cfg <= 8'h0F;
    glb <= 1;
    bus(0, 8'h1C, 0);
    chk("actcfg", 8'h0F, q);
    test_done;
  end
endmodule
